// ==== bench/front_end_model.sv ====
// Conversion front end model: converted samples and the open wire level
`timescale 1ns/1ps
module front_end_model (
  // Clock
  input wire logic clk,
  // Samples to the block
  output logic sampleValid,
  output input_fault_pkg::sample_t sample
);
  // Idle value lines carry the inverse, so stale data never passes as fresh
  initial
  begin
    sampleValid = 1'b0;
    sample = '{wireOpen: 1'b0, value: 20'shFFFFF};
  end
  task automatic set_open(input logic o);
    @(posedge clk);
    sample.wireOpen <= o;
  endtask : set_open
  // One result, valid for a single cycle
  task automatic convert(input logic signed [19:0] v);
    @(posedge clk);
    sampleValid <= 1'b1;
    sample.value <= v;
    @(posedge clk);
    sampleValid <= 1'b0;
    sample.value <= ~v;
  endtask : convert
endmodule : front_end_model

// ==== bench/input_fault_properties.sv ====
// Checker for the APB slave and the input supervision of the fault and alarm block
`timescale 1ns/1ps
module input_fault_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Samples and flags
  input wire logic sampleValid,
  input wire input_fault_pkg::sample_t sample,
  input wire logic pvValid,
  input wire logic inputError,
  input wire logic wireOpenDet
);
  logic mapped;
  // Word aligned offsets up to the last threshold decode
  assign mapped = paddr <= 8'h28 && paddr[1:0] == 2'h0;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_ready;
    s_access |-> pready;
  endproperty
  property p_err_map;
    s_access |-> pslverr == !mapped;
  endproperty
  property p_err_idle;
    pslverr |-> psel && penable;
  endproperty
  // Read data captured at setup must not move after the access
  property p_read_hold;
    s_setup ##1 s_access ##0 !pwrite |=> $stable(prdata);
  endproperty
  property p_pv_lat;
    sampleValid |-> ##2 pvValid;
  endproperty
  property p_pv_cause;
    pvValid |-> $past(sampleValid, 2);
  endproperty
  property p_open_err;
    $rose(wireOpenDet) |-> ##[0:2] inputError;
  endproperty
  property p_open_cause;
    $rose(wireOpenDet) |-> $past(sample.wireOpen, 2);
  endproperty
  property p_open_clear;
    !sample.wireOpen [*4] |-> !wireOpenDet;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err_map: assert property (p_err_map) else $error("pslverr does not match decode");
  a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
  a_read_hold: assert property (p_read_hold) else $error("prdata moved after read");
  a_pv_lat: assert property (p_pv_lat) else $error("pvValid late");
  a_pv_cause: assert property (p_pv_cause) else $error("pvValid without sample");
  a_open_err: assert property (p_open_err) else $error("open wire without error");
  a_open_cause: assert property (p_open_cause) else $error("open seen without wire");
  a_open_clear: assert property (p_open_clear) else $error("open flag stuck");
endmodule : input_fault_properties

bind input_fault_and_level_alarm input_fault_properties props (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sampleValid(sampleValid), .sample(sample), .pvValid(pvValid), .inputError(inputError),
  .wireOpenDet(wireOpenDet));

// ==== bench/tb.sv ====
// Self-checking bench for the input fault and level alarm block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se, sampleValid, pvValid, inputError, wireOpenDet, irq;
  logic [3:0] alm;
  logic signed [19:0] pvOut;
  input_fault_pkg::sample_t sample;
  int fails = 0;
  int check_count = 0;
  int v, n;
  logic [31:0] rnd = 32'hD95E;
  int st[4];
  int thr[4] = '{9000, 8000, 1000, 2000};
  int vals[9] = '{-1501, -1500, -751, -750, 10750, 10751, 11500, 11501, 5000};
  int avals[$] = '{5000, 8500, 7950, 7899, 9000, 1500, 2050, 2101, 1000};
  logic [7:0] ra[12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h40};
  logic [31:0] re[12] = '{32'h10, 0, 0, 0, 0, 0, 0, 32'h2CEC, 32'h2CEC, 32'hFFA24, 32'hFFA24, 0};

  always #5 clk = ~clk;

  // Short counts keep the open wire waits to tens of cycles
  input_fault_and_level_alarm #(.DET_PT4W_CYC(50), .DET_MV_CYC(20), .DET_OTHER_CYC(10), .SEC_CYC(16)) dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid),
    .sample(sample), .pvOut(pvOut), .pvValid(pvValid), .inputError(inputError), .wireOpenDet(wireOpenDet),
    .upperUpperAlarm(alm[0]), .upperAlarm(alm[1]), .lowerLowerAlarm(alm[2]), .lowerAlarm(alm[3]), .irq(irq));
  front_end_model fe (.clk(clk), .sampleValid(sampleValid), .sample(sample));

  // Reference model of substitution, error band and alarm levels
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int det(input int t);
    return t == 1 ? 50 : t == 3 ? 20 : t < 5 ? 10 : 2;
  endfunction : det
  function automatic int xpv(input int t, input int v, input bit o);
    if (!o)
      return v;
    if (t < 5)
      return t % 2 ? 11500 : -1500;
    if (t < 7)
      return -1500;
    return t < 11 ? 0 : 5000;
  endfunction : xpv
  function automatic bit xerr(input int t, input int v, input bit o);
    if (o || v > 11500)
      return 1'b1;
    if (t < 5)
      return v < -1500;
    return t > 10 && (v < -750 || v > 10750);
  endfunction : xerr
  function automatic void upd(input int i, input int v);
    if (i < 2)
      st[i] = st[i] ? int'(v >= thr[i] - 100) : int'(v >= thr[i]);
    else
      st[i] = st[i] ? int'(v <= thr[i] + 100) : int'(v <= thr[i]);
  endfunction : upd

  task automatic report_and_stop();
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // APB master: answer taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      fails++;
  endtask : apb
  task automatic sense(input int t, input int v, input bit o);
    int k;
    k = 0;
    fe.convert(20'(v));
    do
    begin
      tick();
      k++;
    end
    while (pvValid !== 1'b1 && k < 10);
    chk("pv", 32'(xpv(t, v, o)), 32'(pvOut));
    chk("err", 32'(xerr(t, v, o)), 32'(inputError));
  endtask : sense

  initial
  begin
    // About twenty-five times the expected run of roughly a thousand cycles
    #250000;
    fails++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place, read-only and clamped writes
    for (int i = 0; i < 12; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reg", re[i], rd);
      chk("slverr", 32'(i == 11), 32'(se));
    end
    apb(1'b1, 8'h04, 32'h3F);
    apb(1'b0, 8'h04, 32'h0);
    chk("ro", 32'h0, rd);
    apb(1'b1, 8'h18, 32'hC8);
    apb(1'b0, 8'h18, 32'h0);
    chk("delay", 32'h3C, rd);
    // Every input type: band edges, random value, then a disconnection
    for (int t = 0; t < 15; t++)
    begin
      apb(1'b1, 8'h00, {27'h0, t[0], t[3:0]});
      for (int k = 0; k < 10; k++)
      begin
        rnd = lfsr(rnd);
        v = k < 9 ? vals[k] : int'(rnd % 32'h2EE0) - 1000;
        sense(t, v, 1'b0);
      end
      fe.set_open(1'b1);
      n = 0;
      do
      begin
        tick();
        n++;
      end
      while (wireOpenDet !== 1'b1 && n < 80);
      chk("detect", 32'h1, 32'(n >= det(t) - 1 && n <= det(t) + 3));
      sense(t, 3000, 1'b1);
      fe.set_open(1'b0);
      repeat (4) tick();
      chk("open", 32'h0, 32'(wireOpenDet));
      sense(t, 5000, 1'b0);
    end
    // Second reset, then alarms with hysteresis and interrupts
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b1, 8'h00, 32'h5);
    for (int i = 0; i < 4; i++)
      apb(1'b1, 8'h1C + 8'(4 * i), 32'(thr[i]) & 32'hFFFFF);
    apb(1'b1, 8'h14, 32'h64);
    for (int i = 0; i < 4; i++)
      upd(i, 0);
    foreach (avals[k])
    begin
      sense(5, avals[k], 1'b0);
      for (int i = 0; i < 4; i++)
        upd(i, avals[k]);
      repeat (3) tick();
      for (int i = 0; i < 4; i++)
        chk("alarm", 32'(st[i]), 32'(alm[i]));
      if (k == 1)
      begin
        chk("irq", 32'h0, 32'(irq));
        apb(1'b0, 8'h0C, 32'h0);
        chk("irqst", 32'h38, rd);
        apb(1'b1, 8'h10, 32'h8);
        tick();
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, 8'h0C, 32'h38);
        tick();
        chk("irq", 32'h0, 32'(irq));
        apb(1'b0, 8'h0C, 32'h0);
        chk("irqst", 32'h0, rd);
      end
    end
    // Two second delay on set and on release
    apb(1'b1, 8'h18, 32'h2);
    for (int j = 0; j < 2; j++)
    begin
      sense(5, j ? 5000 : 8500, 1'b0);
      repeat (10) tick();
      chk("delay", 32'(j), 32'(alm[1]));
      repeat (30) tick();
      chk("delay", 32'(1 - j), 32'(alm[1]));
    end
    report_and_stop();
  end
endmodule : tb

// ==== hdl/input_fault_and_level_alarm.sv ====
// Input fault supervision and four level alarms for one process input channel
`timescale 1ns/1ps
module input_fault_and_level_alarm #(
  parameter int DET_PT4W_CYC = input_fault_pkg::DETECT_PT4W_CYC,
  parameter int DET_MV_CYC = input_fault_pkg::DETECT_MV_CYC,
  parameter int DET_OTHER_CYC = input_fault_pkg::DETECT_OTHER_CYC,
  parameter int SEC_CYC = input_fault_pkg::SEC_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converted samples from the front end
  input wire logic sampleValid,
  input wire input_fault_pkg::sample_t sample,
  // Supervised value and flags to the controller
  output logic signed [19:0] pvOut,
  output logic pvValid,
  output logic inputError,
  output logic wireOpenDet,
  output logic upperUpperAlarm,
  output logic upperAlarm,
  output logic lowerLowerAlarm,
  output logic lowerAlarm,
  output logic irq
);

  localparam int VW = input_fault_pkg::VAL_W;
  localparam int NA = input_fault_pkg::NUM_ALM;
  localparam int IW = input_fault_pkg::IRQ_W;

  typedef enum {WIRE_OK, WIRE_SUSPECT, WIRE_OPEN} wire_state_t;

  // Registers
  input_fault_pkg::ctrl_t ctrlQ, ctrlD;
  logic [IW-1:0] maskQ, maskD;
  logic [IW-1:0] irqStatQ, irqStatD;
  logic [VW-1:0] hystQ, hystD;
  logic [7:0] delayQ, delayD;
  logic [VW-1:0] thrQ [NA];
  logic [VW-1:0] thrD [NA];
  logic [31:0] prdataQ, prdataD;
  // Channel state
  wire_state_t wireQ, wireD;
  logic [31:0] detCntQ, detCntD;
  logic [31:0] detLimit;
  logic signed [VW-1:0] rawQ, rawD;
  logic newQ, newD;
  logic signed [VW-1:0] pvQ, pvD;
  logic pvValidQ, pvValidD;
  logic errQ, errD;
  logic openQ, openD;
  logic [31:0] secCntQ, secCntD;
  logic secTick;
  logic [NA-1:0] alm;
  logic [NA-1:0] almPrevQ;
  // Decode helpers
  input_fault_pkg::input_class_t cls;
  logic wrEn;
  logic rdSetup;
  logic mapped;
  logic [IW-1:0] events;
  logic outOfBand;
  logic signed [VW-1:0] substitute;

  // Map an address to a threshold index, or NA when it is not a threshold
  function automatic int thrIndex(input logic [7:0] a);
    thrIndex = NA;
    for (int i = 0; i < NA; i++)
      if (a == input_fault_pkg::OFS_THR_BASE + 8'(4 * i))
        thrIndex = i;
  endfunction : thrIndex

  // APB decode; zero wait states, unmapped addresses answer with an error
  always_comb
  begin
    cls = input_fault_pkg::classOf(ctrlQ.inputType);
    wrEn = psel && penable && pwrite;
    rdSetup = psel && !penable && !pwrite;
    case (paddr)
      input_fault_pkg::OFS_CTRL, input_fault_pkg::OFS_STATUS, input_fault_pkg::OFS_PV,
      input_fault_pkg::OFS_IRQ_STATUS, input_fault_pkg::OFS_IRQ_MASK,
      input_fault_pkg::OFS_HYST, input_fault_pkg::OFS_DELAY: mapped = 1'b1;
      default: mapped = (thrIndex(paddr) != NA);
    endcase
    pready = 1'b1;
    pslverr = psel && penable && !mapped;
  end

  // Register writes; interrupt status set wins over a write-one clear
  always_comb
  begin
    ctrlD = ctrlQ;
    maskD = maskQ;
    hystD = hystQ;
    delayD = delayQ;
    for (int i = 0; i < NA; i++)
      thrD[i] = thrQ[i];
    irqStatD = irqStatQ;
    if (wrEn)
    begin
      case (paddr)
        input_fault_pkg::OFS_CTRL: ctrlD = input_fault_pkg::ctrl_t'(pwdata[4:0]);
        input_fault_pkg::OFS_IRQ_MASK: maskD = pwdata[IW-1:0];
        input_fault_pkg::OFS_IRQ_STATUS: irqStatD = irqStatQ & ~pwdata[IW-1:0];
        input_fault_pkg::OFS_HYST: hystD = pwdata[VW-1:0];
        // Longer delays are clamped rather than refused
        input_fault_pkg::OFS_DELAY:
          delayD = (pwdata[7:0] > input_fault_pkg::MAX_DELAY_S) ? input_fault_pkg::MAX_DELAY_S
                                                                : pwdata[7:0];
        default:
          if (thrIndex(paddr) != NA)
            thrD[thrIndex(paddr)] = pwdata[VW-1:0];
      endcase
    end
    irqStatD = irqStatD | events;
  end

  // Read data is captured in the setup phase so it stands through the access phase
  always_comb
  begin
    prdataD = prdataQ;
    if (rdSetup)
    begin
      prdataD = 32'h00000000;
      case (paddr)
        input_fault_pkg::OFS_CTRL: prdataD[4:0] = ctrlQ;
        input_fault_pkg::OFS_STATUS:
        begin
          prdataD[input_fault_pkg::ST_ERR] = errQ;
          prdataD[input_fault_pkg::ST_OPEN] = openQ;
          prdataD[input_fault_pkg::ST_ALM0 +: NA] = alm;
        end
        input_fault_pkg::OFS_PV: prdataD[VW-1:0] = pvQ;
        input_fault_pkg::OFS_IRQ_STATUS: prdataD[IW-1:0] = irqStatQ;
        input_fault_pkg::OFS_IRQ_MASK: prdataD[IW-1:0] = maskQ;
        input_fault_pkg::OFS_HYST: prdataD[VW-1:0] = hystQ;
        input_fault_pkg::OFS_DELAY: prdataD[7:0] = delayQ;
        default:
          if (thrIndex(paddr) != NA)
            prdataD[VW-1:0] = thrQ[thrIndex(paddr)];
      endcase
    end
  end

  // Disconnection must persist for a type-dependent time on sensor inputs
  always_comb
  begin
    case (ctrlQ.inputType)
      input_fault_pkg::IN_PT_4W: detLimit = DET_PT4W_CYC;
      input_fault_pkg::IN_MV_USER: detLimit = DET_MV_CYC;
      default: detLimit = DET_OTHER_CYC;
    endcase
    wireD = wireQ;
    detCntD = detCntQ;
    case (wireQ)
      WIRE_OK:
        if (sample.wireOpen)
        begin
          // Analog ranges report an open loop at once
          wireD = (cls == input_fault_pkg::CLS_SENSOR) ? WIRE_SUSPECT : WIRE_OPEN;
          detCntD = 32'h00000001;
        end
      WIRE_SUSPECT:
        if (!sample.wireOpen)
          wireD = WIRE_OK;
        else if (detCntQ >= detLimit - 1)
          wireD = WIRE_OPEN;
        else
          detCntD = detCntQ + 32'h00000001;
      WIRE_OPEN:
        if (!sample.wireOpen)
          wireD = WIRE_OK;
      default: wireD = WIRE_OK;
    endcase
  end

  // Range check and substitute value; re-evaluated every cycle so errors clear by themselves
  always_comb
  begin
    rawD = sampleValid ? sample.value : rawQ;
    newD = sampleValid;
    case (cls)
      input_fault_pkg::CLS_SENSOR:
      begin
        outOfBand = (rawQ < input_fault_pkg::PCT_M15) || (rawQ > input_fault_pkg::PCT_P115);
        substitute = ctrlQ.burnoutHigh ? input_fault_pkg::PCT_P115 : input_fault_pkg::PCT_M15;
      end
      input_fault_pkg::CLS_LIVE_ZERO:
      begin
        outOfBand = rawQ > input_fault_pkg::PCT_P115;
        substitute = input_fault_pkg::PCT_M15;
      end
      input_fault_pkg::CLS_UNIPOLAR:
      begin
        outOfBand = rawQ > input_fault_pkg::PCT_P115;
        // Zero of a unipolar scale is 0 V or 0 mA alike
        substitute = input_fault_pkg::PV_ZERO;
      end
      default:
      begin
        outOfBand = (rawQ < input_fault_pkg::PCT_M7P5) || (rawQ > input_fault_pkg::PCT_P107P5);
        substitute = input_fault_pkg::PV_BIPOLAR_ZERO;
      end
    endcase
    openD = (wireQ == WIRE_OPEN);
    // Disconnection on every range also raises the error flag
    errD = openD || outOfBand;
    pvD = openD ? substitute : rawQ;
    pvValidD = newQ;
  end

  // One-second tick for the alarm delays
  always_comb
  begin
    secTick = (secCntQ >= SEC_CYC - 1);
    secCntD = secTick ? 32'h00000000 : secCntQ + 32'h00000001;
  end

  // Rising edges of the flags become interrupt events
  always_comb
  begin
    events = '0;
    events[input_fault_pkg::EV_ERR] = errQ && !errD ? 1'b0 : (errD && !errQ);
    events[input_fault_pkg::EV_OPEN] = openD && !openQ;
    events[input_fault_pkg::EV_ALM0 +: NA] = alm & ~almPrevQ;
  end

  // All state registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrlQ <= input_fault_pkg::CTRL_RST;
      maskQ <= '0;
      irqStatQ <= '0;
      hystQ <= '0;
      delayQ <= 8'h00;
      thrQ[input_fault_pkg::ALM_UU] <= input_fault_pkg::PCT_P115;
      thrQ[input_fault_pkg::ALM_U] <= input_fault_pkg::PCT_P115;
      thrQ[input_fault_pkg::ALM_LL] <= input_fault_pkg::PCT_M15;
      thrQ[input_fault_pkg::ALM_L] <= input_fault_pkg::PCT_M15;
      prdataQ <= 32'h00000000;
      wireQ <= WIRE_OK;
      detCntQ <= 32'h00000000;
      rawQ <= input_fault_pkg::PV_ZERO;
      newQ <= 1'b0;
      pvQ <= input_fault_pkg::PV_ZERO;
      pvValidQ <= 1'b0;
      errQ <= 1'b0;
      openQ <= 1'b0;
      secCntQ <= 32'h00000000;
      almPrevQ <= '0;
    end
    else
    begin
      ctrlQ <= ctrlD;
      maskQ <= maskD;
      irqStatQ <= irqStatD;
      hystQ <= hystD;
      delayQ <= delayD;
      for (int i = 0; i < NA; i++)
        thrQ[i] <= thrD[i];
      prdataQ <= prdataD;
      wireQ <= wireD;
      detCntQ <= detCntD;
      rawQ <= rawD;
      newQ <= newD;
      pvQ <= pvD;
      pvValidQ <= pvValidD;
      errQ <= errD;
      openQ <= openD;
      secCntQ <= secCntD;
      almPrevQ <= alm;
    end
  end

  // Four alarms on the supervised value, upper pair trips above, lower pair below
  for (genvar g = 0; g < NA; g++)
  begin : gen_alarm
    // Value width left at its default, which matches the package width
    level_alarm #(
      .ABOVE(g < input_fault_pkg::ALM_LL)
    ) u_alarm (
      .clk(clk),
      .rst_b(rst_b),
      .value(pvQ),
      .threshold(thrQ[g]),
      .hysteresis(hystQ),
      .delaySec(delayQ),
      .secTick(secTick),
      .alarm(alm[g])
    );
  end

  // Outputs
  assign prdata = prdataQ;
  assign pvOut = pvQ;
  assign pvValid = pvValidQ;
  assign inputError = errQ;
  assign wireOpenDet = openQ;
  assign upperUpperAlarm = alm[input_fault_pkg::ALM_UU];
  assign upperAlarm = alm[input_fault_pkg::ALM_U];
  assign lowerLowerAlarm = alm[input_fault_pkg::ALM_LL];
  assign lowerAlarm = alm[input_fault_pkg::ALM_L];
  // Level interrupt while any unmasked status bit stands
  assign irq = |(irqStatQ & maskQ);

endmodule : input_fault_and_level_alarm

// ==== hdl/input_fault_pkg.sv ====
// Shared constants, types and decoding for the input fault and level alarm block
package input_fault_pkg;

  // Process value scale: 0x2710 counts span 100.00 % of the set range
  localparam int VAL_W = 20;
  localparam logic signed [19:0] PCT_M15 = -20'sh005DC;
  localparam logic signed [19:0] PCT_P115 = 20'sh02CEC;
  localparam logic signed [19:0] PCT_M7P5 = -20'sh002EE;
  localparam logic signed [19:0] PCT_P107P5 = 20'sh029FE;
  localparam logic signed [19:0] PV_ZERO = 20'sh00000;
  localparam logic signed [19:0] PV_BIPOLAR_ZERO = 20'sh01388;

  // Timing
  localparam int CLK_HZ = 32'h05F5E100;
  localparam int MS_PER_S = 32'h000003E8;
  localparam int DETECT_PT4W_MS = 32'h00001388;
  localparam int DETECT_MV_MS = 32'h000003E8;
  localparam int DETECT_OTHER_MS = 32'h000001F4;
  localparam int DETECT_PT4W_CYC = DETECT_PT4W_MS * (CLK_HZ / MS_PER_S);
  localparam int DETECT_MV_CYC = DETECT_MV_MS * (CLK_HZ / MS_PER_S);
  localparam int DETECT_OTHER_CYC = DETECT_OTHER_MS * (CLK_HZ / MS_PER_S);
  localparam int SEC_CYC = CLK_HZ;
  localparam logic [7:0] MAX_DELAY_S = 8'h3C;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PV = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_HYST = 8'h14;
  localparam logic [7:0] OFS_DELAY = 8'h18;
  localparam logic [7:0] OFS_THR_BASE = 8'h1C;

  // Alarm order within threshold and status fields
  localparam int NUM_ALM = 4;
  localparam int ALM_UU = 0;
  localparam int ALM_U = 1;
  localparam int ALM_LL = 2;
  localparam int ALM_L = 3;

  // Event bits in the interrupt status and mask
  localparam int IRQ_W = 6;
  localparam int EV_ERR = 0;
  localparam int EV_OPEN = 1;
  localparam int EV_ALM0 = 2;

  // Status register fields
  localparam int ST_ERR = 0;
  localparam int ST_OPEN = 1;
  localparam int ST_ALM0 = 2;

  typedef enum logic [3:0] {
    IN_PT_3W, IN_PT_4W, IN_TC, IN_MV_USER, IN_POT,
    IN_I_4_20, IN_V_1_5, IN_V_0_1P25, IN_V_0_5, IN_V_0_10, IN_I_0_20,
    IN_V_PM_1P25, IN_V_PM_5, IN_V_PM_10, IN_V_USER_10
  } input_type_t;

  typedef enum logic [1:0] {CLS_SENSOR, CLS_LIVE_ZERO, CLS_UNIPOLAR, CLS_BIPOLAR} input_class_t;

  // Control register layout, bit 4 burnout direction, bits 3:0 input type
  typedef struct packed {
    logic burnoutHigh;
    input_type_t inputType;
  } ctrl_t;

  // One converted value from the front end
  typedef struct packed {
    logic wireOpen;
    logic signed [19:0] value;
  } sample_t;

  localparam ctrl_t CTRL_RST = '{burnoutHigh: 1'b1, inputType: IN_PT_3W};

  // Group input types by their fault handling
  function automatic input_class_t classOf(input input_type_t t);
    case (t)
      IN_PT_3W, IN_PT_4W, IN_TC, IN_MV_USER, IN_POT: classOf = CLS_SENSOR;
      IN_I_4_20, IN_V_1_5: classOf = CLS_LIVE_ZERO;
      IN_V_0_1P25, IN_V_0_5, IN_V_0_10, IN_I_0_20: classOf = CLS_UNIPOLAR;
      default: classOf = CLS_BIPOLAR;
    endcase
  endfunction : classOf

endpackage : input_fault_pkg

// ==== hdl/level_alarm.sv ====
// One process value level alarm with hysteresis and on/off delay
`timescale 1ns/1ps
module level_alarm #(
  parameter int VAL_W = 20,
  parameter bit ABOVE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Value and settings
  input wire logic signed [VAL_W-1:0] value,
  input wire logic signed [VAL_W-1:0] threshold,
  input wire logic [VAL_W-1:0] hysteresis,
  input wire logic [7:0] delaySec,
  input wire logic secTick,
  // Delayed alarm
  output logic alarm
);

  logic rawQ;
  logic rawD;
  logic alarmQ;
  logic alarmD;
  logic [7:0] cntQ;
  logic [7:0] cntD;
  logic signed [VAL_W:0] valX;
  logic signed [VAL_W:0] thrX;
  logic signed [VAL_W:0] relX;

  // Undelayed level with hysteresis; extra bit keeps threshold +/- hysteresis from wrapping
  always_comb
  begin
    valX = {value[VAL_W-1], value};
    thrX = {threshold[VAL_W-1], threshold};
    relX = ABOVE ? thrX - $signed({1'b0, hysteresis}) : thrX + $signed({1'b0, hysteresis});
    rawD = rawQ;
    if (!rawQ)
      rawD = ABOVE ? (valX >= thrX) : (valX <= thrX);
    else if (ABOVE ? (valX < relX) : (valX > relX))
      rawD = 1'b0;
  end

  // Delay both edges by whole seconds; shared tick can cut up to one second off each delay
  always_comb
  begin
    alarmD = alarmQ;
    cntD = cntQ;
    if (rawQ == alarmQ)
      cntD = 8'h00;
    else if (cntQ >= delaySec)
    begin
      alarmD = rawQ;
      cntD = 8'h00;
    end
    else if (secTick)
      cntD = cntQ + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rawQ <= 1'b0;
      alarmQ <= 1'b0;
      cntQ <= 8'h00;
    end
    else
    begin
      rawQ <= rawD;
      alarmQ <= alarmD;
      cntQ <= cntD;
    end
  end

  assign alarm = alarmQ;

endmodule : level_alarm
